// ===== rtl/idm_decode.sv
// identification registers and reset-time memory map decode over AHB-Lite
`timescale 1ns/100ps
module idm_decode
  import idm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [2:0] REGION
);

  logic acc;
  logic hit_low;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [11:0] wr_addr_reg;
  logic [11:0] wr_addr_next;
  logic [18:0] probe_reg;
  logic [18:0] probe_next;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [15:0] part_ident_value;

  // decode a cpu address and page into the result byte
  function automatic logic [7:0] map_decode(input logic [18:0] p);
    logic [15:0] a;
    logic [2:0] rgn;
    logic ee_hidden;
    logic ram_hidden;
    a = p[15:0];
    rgn = RGN_NONE;
    ee_hidden = 1'b0;
    ram_hidden = 1'b0;
    // register space wins over ram, ram wins over eeprom
    if (a < MAP_REG_END) begin
      rgn = (a >= MAP_ID_START && a < MAP_ID_END) ? RGN_ID : RGN_REG;
      ram_hidden = 1'b1;
    end else if (a < MAP_RAM_END) begin
      rgn = RGN_RAM;
    end else if (a < MAP_FIX_LO_START) begin
      rgn = RGN_NONE;
    end else if (a < MAP_WINDOW_START) begin
      rgn = RGN_FIX_LO;
    end else if (a < MAP_FIX_HI_START) begin
      rgn = RGN_WINDOW;
    end else if (a < MAP_VECTOR_START) begin
      rgn = RGN_FIX_HI;
    end else begin
      rgn = RGN_VECTOR;
    end
    // eeprom only flags its shadowing, it is never selected
    ee_hidden = (a < MAP_EEPROM_END);
    map_decode = {p[18:16], ram_hidden, ee_hidden, rgn};
  endfunction

  // widen a byte register to the bus word, upper bytes read as zero
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  // id value is packed from its four nibbles
  assign part_ident_value = {ID_MAJOR_FAMILY, ID_MINOR_FAMILY,
                             ID_MAJOR_MASK, ID_MINOR_MASK};

  // address phase qualifier for this slave; with HREADY low another
  // transfer still owns the bus, so latching an address then would
  // start a phase that is not ours
  assign acc = HSEL & HTRANS[1] & HREADY;
  assign hit_low = (HADDR[31:12] == 20'h00000);

  // write pipeline and probe register next values
  always_comb begin
    // a write outside the low 4K page must not land on the probe
    wr_pend_next = acc & HWRITE & hit_low;
    wr_addr_next = HADDR[11:0];
    probe_next = probe_reg;
    // only the probe takes write data; id and size writes fall away
    if (wr_pend_reg && wr_addr_reg == ADDR_DECODE_PROBE) begin
      probe_next = HWDATA[18:0];
    end
    result_next = map_decode(probe_next);
  end

  // read mux sees the probe value a write in flight is about to leave,
  // so a read right behind a write needs no wait state
  always_comb begin
    rdata_next = 32'h00000000;
    if (acc && !HWRITE && hit_low) begin
      unique case (HADDR[11:0])
        ADDR_PART_IDENT_HIGH:
          rdata_next = byte_word(part_ident_value[15:8]);
        ADDR_PART_IDENT_LOW:
          rdata_next = byte_word(part_ident_value[7:0]);
        ADDR_MEMORY_SIZE_FIRST:
          rdata_next = byte_word(MEMORY_SIZE_FIRST_VAL);
        ADDR_MEMORY_SIZE_SECOND:
          rdata_next = byte_word(MEMORY_SIZE_SECOND_VAL);
        ADDR_DECODE_PROBE:
          rdata_next = {13'h0000, probe_next};
        ADDR_DECODE_RESULT:
          rdata_next = byte_word(result_next);
        default:
          rdata_next = 32'h00000000;
      endcase
    end
  end

  // bus and decode state registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      probe_reg <= PROBE_RESET;
      result_reg <= RESULT_RESET;
      rdata_reg <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      probe_reg <= probe_next;
      result_reg <= result_next;
      rdata_reg <= rdata_next;
    end
  end

  // zero wait states and always okay: nothing here can stall or fail
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  assign HRDATA = rdata_reg;
  assign REGION = result_reg[2:0];

  // address phase of a read at a given byte address
  sequence s_rd(logic [11:0] ad);
    acc && !HWRITE && HADDR == {20'h00000, ad};
  endsequence

  // address phase of a write followed by its data phase
  sequence s_wr(logic [11:0] ad);
    acc && HWRITE && HADDR == {20'h00000, ad} ##1 1'b1;
  endsequence

  // probe write whose data lies in [lo, hi)
  sequence s_probe(logic [15:0] lo, logic [15:0] hi);
    s_wr(ADDR_DECODE_PROBE) ##0
      (HWDATA[15:0] >= lo && HWDATA[15:0] < hi);
  endsequence

  // two reads from a master that idles a cycle between transfers: the
  // second address phase is sampled two edges after the first
  sequence s_rd_pair(logic [11:0] first, logic [11:0] second);
    s_rd(first) ##2 s_rd(second);
  endsequence

  // write to one register, then a read of the same one right behind it
  sequence s_wr_then_rd(logic [11:0] ad);
    s_wr(ad) ##1 s_rd(ad);
  endsequence

  // any write aimed at the id or memory size registers
  sequence s_wr_ro;
    acc && HWRITE && hit_low &&
      (HADDR[11:0] == ADDR_PART_IDENT_HIGH ||
       HADDR[11:0] == ADDR_PART_IDENT_LOW ||
       HADDR[11:0] == ADDR_MEMORY_SIZE_FIRST ||
       HADDR[11:0] == ADDR_MEMORY_SIZE_SECOND);
  endsequence

  // timing these checks lean on: read data stands for the cycle after
  // its address phase; a probe write lands at the edge closing its data
  // phase and shows on REGION from then on, until the next probe write

  AST_ID_HIGH: assert property (
    @(posedge MCLK) disable iff (RST)
    s_rd(ADDR_PART_IDENT_HIGH) |=>
      HRDATA == {24'h000000, part_ident_value[15:8]})
    else $error("id high byte wrong");

  AST_ID_LOW: assert property (
    @(posedge MCLK) disable iff (RST)
    s_rd(ADDR_PART_IDENT_LOW) |=>
      HRDATA == {24'h000000, part_ident_value[7:0]} && HREADYOUT)
    else $error("id low byte wrong");

  AST_ID_NIBBLES: assert property (
    @(posedge MCLK) disable iff (RST)
    s_rd_pair(ADDR_PART_IDENT_HIGH, ADDR_PART_IDENT_LOW) |=>
      $past(HRDATA[7:4], 2) == ID_MAJOR_FAMILY &&
      $past(HRDATA[3:0], 2) == ID_MINOR_FAMILY &&
      HRDATA[7:4] == ID_MAJOR_MASK && HRDATA[3:0] == ID_MINOR_MASK)
    else $error("id nibble order wrong");

  AST_SIZE_FIRST: assert property (
    @(posedge MCLK) disable iff (RST)
    s_rd(ADDR_MEMORY_SIZE_FIRST) |=> HRDATA == 32'h00000013)
    else $error("first memory size wrong");

  AST_SIZE_SECOND: assert property (
    @(posedge MCLK) disable iff (RST)
    s_rd(ADDR_MEMORY_SIZE_SECOND) |=> HRDATA == 32'h00000080 && !HRESP)
    else $error("second memory size wrong");

  AST_REG_OVER_RAM: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(16'h0000, MAP_REG_END) ##0 !(HWDATA[15:0] >= MAP_ID_START &&
      HWDATA[15:0] < MAP_ID_END) |=>
      REGION == RGN_REG && result_reg[RES_RAM_HIDDEN])
    else $error("register space not over ram");

  AST_RAM_ABOVE_REG: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(MAP_REG_END, MAP_RAM_END) |=>
      REGION == RGN_RAM && !result_reg[RES_RAM_HIDDEN])
    else $error("ram not decoded");

  AST_EEPROM_HIDDEN: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(16'h0000, MAP_EEPROM_END) |=>
      result_reg[RES_EE_HIDDEN] && (REGION == RGN_RAM ||
      REGION == RGN_REG || REGION == RGN_ID))
    else $error("eeprom became visible");

  AST_WINDOW: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(MAP_WINDOW_START, MAP_FIX_HI_START) |=>
      REGION == RGN_WINDOW &&
      result_reg[7:RES_PAGE_LSB] == $past(HWDATA[18:16]))
    else $error("page window decode wrong");

  AST_FIXED_LOW: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(MAP_FIX_LO_START, MAP_WINDOW_START) |=> REGION == RGN_FIX_LO)
    else $error("lower fixed flash wrong");

  AST_VECTOR: assert property (
    @(posedge MCLK) disable iff (RST)
    s_wr(ADDR_DECODE_PROBE) ##0 HWDATA[15:8] == 8'hFF |=>
      REGION == RGN_VECTOR)
    else $error("vector area wrong");

  AST_FIXED_HIGH: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(MAP_FIX_HI_START, MAP_VECTOR_START) |=> REGION == RGN_FIX_HI)
    else $error("upper fixed flash wrong");

  AST_ID_SLOT: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(MAP_ID_START, MAP_ID_END) |=>
      REGION == RGN_ID ##1 REGION == RGN_ID)
    else $error("id slot not decoded");

  AST_WRITE_IGNORED: assert property (
    @(posedge MCLK) disable iff (RST)
    s_wr_then_rd(ADDR_PART_IDENT_HIGH) |=>
      HRDATA == {24'h000000, part_ident_value[15:8]})
    else $error("id write took effect");

  AST_SIZE_WRITE_IGNORED: assert property (
    @(posedge MCLK) disable iff (RST)
    s_wr_then_rd(ADDR_MEMORY_SIZE_FIRST) |=>
      HRDATA == 32'h00000013)
    else $error("memory size write took effect");

  // out of reset the probe sits on address zero, inside register space
  AST_RESET_MAP: assert property (
    @(posedge MCLK) disable iff (RST)
    $fell(RST) |-> REGION == RGN_REG && result_reg[RES_RAM_HIDDEN] &&
      result_reg[RES_EE_HIDDEN] && HRDATA == 32'h00000000)
    else $error("map out of reset wrong");

  AST_ID_BELOW_SLOT: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(16'h0000, MAP_ID_START) |=> REGION == RGN_REG)
    else $error("id slot starts too low");

  AST_ID_ABOVE_SLOT: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(MAP_ID_END, MAP_REG_END) |=> REGION == RGN_REG)
    else $error("id slot ends too high");

  AST_EEPROM_ABOVE: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(MAP_EEPROM_END, MAP_RAM_END) |=>
      REGION == RGN_RAM && !result_reg[RES_EE_HIDDEN])
    else $error("eeprom shadow flag too wide");

  AST_GAP_UNMAPPED: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(MAP_RAM_END, MAP_FIX_LO_START) |=>
      REGION == RGN_NONE && !result_reg[RES_RAM_HIDDEN])
    else $error("gap below fixed flash decoded");

  AST_RAM_HIDDEN_FLAG: assert property (
    @(posedge MCLK) disable iff (RST)
    result_reg[RES_RAM_HIDDEN] |-> (REGION == RGN_REG || REGION == RGN_ID))
    else $error("ram hidden outside register space");

  AST_TOP_PAGE: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(MAP_WINDOW_START, MAP_FIX_HI_START) ##0
      HWDATA[18:16] == 3'h7 |=>
      REGION == RGN_WINDOW && result_reg[7:RES_PAGE_LSB] == 3'h7)
    else $error("top flash page not reached");

  AST_MID_PAGE: assert property (
    @(posedge MCLK) disable iff (RST)
    s_probe(MAP_WINDOW_START, MAP_FIX_HI_START) ##0
      HWDATA[18:16] == 3'h3 |=>
      REGION == RGN_WINDOW && result_reg[7:RES_PAGE_LSB] == 3'h3)
    else $error("middle flash page not reached");

  // a stray decode of a read-only write would move the probe one edge
  // after the address phase, so look one edge later still
  AST_RO_NO_SIDE_EFFECT: assert property (
    @(posedge MCLK) disable iff (RST)
    s_wr_ro |=> ##1 $stable(probe_reg) && $stable(result_reg))
    else $error("read-only write disturbed the probe");

  // only a probe write in its data phase may move the probe
  AST_PROBE_HOLDS: assert property (
    @(posedge MCLK) disable iff (RST)
    !wr_pend_reg |=> $stable(probe_reg))
    else $error("probe moved with no write");

endmodule

// ===== rtl/idm_pkg.sv
// constants for the identification and memory map decode block
package idm_pkg;
  // register indices as printed, byte address is four times the index
  localparam logic [11:0] IDX_PART_IDENT_HIGH = 12'h01A;
  localparam logic [11:0] IDX_PART_IDENT_LOW = 12'h01B;
  localparam logic [11:0] IDX_MEMORY_SIZE_FIRST = 12'h01C;
  localparam logic [11:0] IDX_MEMORY_SIZE_SECOND = 12'h01D;
  localparam logic [11:0] ADDR_PART_IDENT_HIGH = 12'h068;
  localparam logic [11:0] ADDR_PART_IDENT_LOW = 12'h06C;
  localparam logic [11:0] ADDR_MEMORY_SIZE_FIRST = 12'h070;
  localparam logic [11:0] ADDR_MEMORY_SIZE_SECOND = 12'h074;
  // decode probe registers
  localparam logic [11:0] ADDR_DECODE_PROBE = 12'h200;
  localparam logic [11:0] ADDR_DECODE_RESULT = 12'h204;
  // fixed memory size values
  localparam logic [7:0] MEMORY_SIZE_FIRST_VAL = 8'h13;
  localparam logic [7:0] MEMORY_SIZE_SECOND_VAL = 8'h80;
  // part identification nibbles, values are arbitrary
  localparam logic [3:0] ID_MAJOR_FAMILY = 4'h1;
  localparam logic [3:0] ID_MINOR_FAMILY = 4'h2;
  localparam logic [3:0] ID_MAJOR_MASK = 4'h3;
  localparam logic [3:0] ID_MINOR_MASK = 4'h4;
  // reset-time map boundaries
  localparam logic [15:0] MAP_REG_END = 16'h0400;
  localparam logic [15:0] MAP_ID_START = 16'h001A;
  localparam logic [15:0] MAP_ID_END = 16'h001C;
  localparam logic [15:0] MAP_EEPROM_END = 16'h0800;
  localparam logic [15:0] MAP_RAM_END = 16'h2000;
  localparam logic [15:0] MAP_FIX_LO_START = 16'h4000;
  localparam logic [15:0] MAP_WINDOW_START = 16'h8000;
  localparam logic [15:0] MAP_FIX_HI_START = 16'hC000;
  localparam logic [15:0] MAP_VECTOR_START = 16'hFF00;
  // region codes
  localparam logic [2:0] RGN_NONE = 3'h0;
  localparam logic [2:0] RGN_REG = 3'h1;
  localparam logic [2:0] RGN_ID = 3'h2;
  localparam logic [2:0] RGN_RAM = 3'h3;
  localparam logic [2:0] RGN_FIX_LO = 3'h4;
  localparam logic [2:0] RGN_WINDOW = 3'h5;
  localparam logic [2:0] RGN_FIX_HI = 3'h6;
  localparam logic [2:0] RGN_VECTOR = 3'h7;
  // result field positions
  localparam int RES_EE_HIDDEN = 3;
  localparam int RES_RAM_HIDDEN = 4;
  localparam int RES_PAGE_LSB = 5;
  localparam logic [18:0] PROBE_RESET = 19'h00000;
  // the result register resets to the decode of probe address zero
  localparam logic [7:0] RESULT_RESET = 8'h19;
endpackage

// ===== verification/testbench.sv
// self-checking bench for the id registers and memory map decode block
`timescale 1ns/100ps
module testbench;
  import idm_pkg::*;
  logic MCLK;
  logic RST;
  logic HSEL;
  logic [31:0] HADDR;
  logic [1:0] HTRANS;
  logic HWRITE;
  logic [2:0] HSIZE;
  logic [31:0] HWDATA;
  wire logic HREADY;
  wire logic [31:0] HRDATA;
  wire logic HREADYOUT;
  wire logic HRESP;
  wire logic [2:0] REGION;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rdata;
  logic [7:0] id_hi;
  logic [7:0] id_lo;
  // probe addresses at every map boundary, with their page and region
  logic [15:0] pa[20] = '{16'h0000, 16'h0019, 16'h001A, 16'h001B,
    16'h001C, 16'h03FF, 16'h0400, 16'h07FF, 16'h0800, 16'h1FFF,
    16'h2000, 16'h3FFF, 16'h4000, 16'h7FFF, 16'h8000, 16'hBFFF,
    16'hC000, 16'hFEFF, 16'hFF00, 16'hFFFF};
  logic [2:0] pg[20] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
    3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h3, 3'h0, 3'h0,
    3'h0, 3'h0};
  logic [2:0] rg[20] = '{RGN_REG, RGN_REG, RGN_ID, RGN_ID, RGN_REG,
    RGN_REG, RGN_RAM, RGN_RAM, RGN_RAM, RGN_RAM, RGN_NONE, RGN_NONE,
    RGN_FIX_LO, RGN_FIX_LO, RGN_WINDOW, RGN_WINDOW, RGN_FIX_HI,
    RGN_FIX_HI, RGN_VECTOR, RGN_VECTOR};
  logic [7:0] exp_res;

  // one slave, so its ready is the bus ready
  assign HREADY = HREADYOUT;

  idm_decode idm_decode_inst (
    .MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .REGION(REGION)
  );

  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // single word transfer; address phase held until ready, then data phase
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {20'h00000, a};
    HWRITE <= wr;
    HSIZE <= 3'b010;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    HTRANS <= 2'b00;
    HSEL <= 1'b0;
    HWDATA <= wd;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    rd = HRDATA;
    check({31'h0, HRESP}, 32'h0);
  endtask

  // hang guard, the whole sequence needs about 150 cycles
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    RST = 1'b1;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'b010;
    HWDATA = 32'h0;
    id_hi = {ID_MAJOR_FAMILY, ID_MINOR_FAMILY};
    id_lo = {ID_MAJOR_MASK, ID_MINOR_MASK};
    repeat (10) @(posedge MCLK);
    check({29'h0, REGION}, {29'h0, RGN_REG});
    check({31'h0, HREADYOUT}, 32'h1);
    RST <= 1'b0;
    @(posedge MCLK);
    // id and size bytes, then writes that must leave them alone
    repeat (2) begin
      xfer(1'b0, ADDR_PART_IDENT_HIGH, 32'h0, rdata);
      check(rdata, {24'h0, id_hi});
      xfer(1'b0, ADDR_PART_IDENT_LOW, 32'h0, rdata);
      check(rdata, {24'h0, id_lo});
      xfer(1'b0, ADDR_MEMORY_SIZE_FIRST, 32'h0, rdata);
      check(rdata, 32'h00000013);
      xfer(1'b0, ADDR_MEMORY_SIZE_SECOND, 32'h0, rdata);
      check(rdata, 32'h00000080);
      xfer(1'b1, ADDR_PART_IDENT_HIGH, 32'hFFFFFFFF, rdata);
      xfer(1'b0, ADDR_PART_IDENT_HIGH, 32'h0, rdata);
      check(rdata, {24'h0, id_hi});
      xfer(1'b1, ADDR_PART_IDENT_LOW, 32'h00000000, rdata);
      xfer(1'b1, ADDR_MEMORY_SIZE_FIRST, 32'h000000EC, rdata);
      xfer(1'b0, ADDR_MEMORY_SIZE_FIRST, 32'h0, rdata);
      check(rdata, 32'h00000013);
      xfer(1'b1, ADDR_MEMORY_SIZE_SECOND, 32'h0000007F, rdata);
    end
    // unmapped word reads zero and ignores writes
    xfer(1'b1, 12'h100, 32'hA5A5A5A5, rdata);
    xfer(1'b0, 12'h100, 32'h0, rdata);
    check(rdata, 32'h0);
    // walk the reset map across every boundary
    for (int i = 0; i < 20; i++) begin
      exp_res = {(rg[i] == RGN_WINDOW) ? pg[i] : 3'h0,
                 pa[i] < 16'h0400, pa[i] < 16'h0800, rg[i]};
      xfer(1'b1, ADDR_DECODE_PROBE, {13'h0, pg[i], pa[i]}, rdata);
      xfer(1'b0, ADDR_DECODE_RESULT, 32'h0, rdata);
      check(rdata, {24'h0, exp_res});
      check({29'h0, REGION}, {29'h0, rg[i]});
    end
    xfer(1'b0, ADDR_DECODE_PROBE, 32'h0, rdata);
    check(rdata, 32'h0000FFFF);
    xfer(1'b1, ADDR_DECODE_RESULT, 32'h000000FF, rdata);
    xfer(1'b0, ADDR_DECODE_RESULT, 32'h0, rdata);
    check(rdata, 32'h00000007);
    // second reset in mid-run returns the probe to address zero
    RST <= 1'b1;
    repeat (3) @(posedge MCLK);
    check({29'h0, REGION}, {29'h0, RGN_REG});
    RST <= 1'b0;
    @(posedge MCLK);
    xfer(1'b0, ADDR_DECODE_PROBE, 32'h0, rdata);
    check(rdata, 32'h0);
    xfer(1'b0, ADDR_DECODE_RESULT, 32'h0, rdata);
    check(rdata, 32'h00000019);
    xfer(1'b0, ADDR_PART_IDENT_HIGH, 32'h0, rdata);
    check(rdata, {24'h0, id_hi});
    repeat (2) @(posedge MCLK);
    end_of_test();
  end
endmodule
